// ==== dmrq_cfg.svh ====
// Purpose: constants for the dma request and mask control block
// Assumes: register index times four gives the axi byte address
// Notes: indices below 0x40 mirror the legacy port numbers
`ifndef DMRQ_CFG_SVH
`define DMRQ_CFG_SVH
`define DMRQ_AW 12
`define DMRQ_IX_STAT_LO 10'h008
`define DMRQ_IX_REQ_LO 10'h009
`define DMRQ_IX_MASK_LO 10'h00a
`define DMRQ_IX_EXT_LO 10'h00b
`define DMRQ_IX_CLR_LO 10'h00d
`define DMRQ_IX_STAT_HI 10'h0d0
`define DMRQ_IX_REQ_HI 10'h0d2
`define DMRQ_IX_MASK_HI 10'h0d4
`define DMRQ_IX_EXT_HI 10'h0d6
`define DMRQ_IX_CLR_HI 10'h0da
`define DMRQ_IX_CFG 10'h040
`define DMRQ_IX_LOAD 10'h041
`define DMRQ_SETCLR_BIT 2
`define DMRQ_EXT_LSB 2
`define DMRQ_LOAD_CH_LSB 16
`define DMRQ_LOAD_CNT_BIT 19
`define DMRQ_MASK_RST 8'h0ff
`define DMRQ_REQ_RST 8'h00
`define DMRQ_CFG_RST 16'h0000
`define DMRQ_RESP_OKAY 2'h0
`define DMRQ_RESP_SLVERR 2'h2
`define DMRQ_CASCADE_CH 4
`endif

// ==== dmrq_pkg.sv ====
// Purpose: shared types for the dma request and mask control block
// Assumes: sixteen-bit channel address and count counters
// Notes: none
package dmrq_pkg;
  typedef enum logic [1:0] {
    DMRQ_AM_8B = 2'b00,
    DMRQ_AM_16W = 2'b01,
    DMRQ_AM_32B = 2'b10,
    DMRQ_AM_16B = 2'b11
  } dmrq_amode_t;
  typedef enum logic [1:0] {
    DMRQ_WR_IDLE = 2'b01,
    DMRQ_WR_RESP = 2'b10
  } dmrq_wr_state_t;
  typedef struct packed {
    dmrq_amode_t mode;
    logic dec;
    logic [15:0] addr;
    logic [15:0] cnt;
  } dmrq_step_in_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] cnt;
    logic [1:0] be;
    logic tc;
  } dmrq_step_out_t;
endpackage : dmrq_pkg

// ==== dmrq_sync.sv ====
// Purpose: two-flop synchroniser for the request pins
// Assumes: pins are asynchronous to aclk
// Notes: the first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module dmrq_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] d,
  output logic [7:0] q
);
  logic [7:0] meta_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 8'h00;
      q <= 8'h00;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : dmrq_sync
`default_nettype wire

// ==== dmrq_step.sv ====
// Purpose: one bus cycle step of a channel's address and count
// Assumes: count holds remaining units minus one
// Notes: combinational; terminal count is the count wrapping below zero
`timescale 1ns/10ps
`default_nettype none
module dmrq_step
  import dmrq_pkg::*;
(
  input wire dmrq_step_in_t si,
  output var dmrq_step_out_t so
);
  logic [15:0] base;
  logic [15:0] step;
  logic [15:0] units;
  always_comb begin
    base = si.addr;
    step = 16'h0001;
    units = 16'h0001;
    so.be = 2'b11;
    unique case (si.mode)
      DMRQ_AM_8B: so.be = 2'b01;
      DMRQ_AM_16W: so.be = 2'b11;
      DMRQ_AM_32B: begin
        step = 16'h0004;
        units = 16'h0004;
      end
      DMRQ_AM_16B: begin
        // any byte address accepted; odd start moves the upper byte only
        base = {si.addr[15:1], 1'b0};
        step = 16'h0002;
        if (si.addr[0]) begin
          so.be = 2'b10;
        end else if (si.cnt == 16'h0000) begin
          so.be = 2'b01;
        end else begin
          units = 16'h0002;
        end
      end
    endcase
    so.addr = si.dec ? base - step : base + step;
    so.cnt = si.cnt - units;
    so.tc = si.cnt < units;
  end
endmodule : dmrq_step
`default_nettype wire

// ==== dmrq_top.sv ====
// Purpose: request and mask control for two cascaded four-channel groups
// Assumes: axi4-lite master, 8-bit registers in lane 0 of each word, except cfg [15:0] and load [19:0]
`timescale 1ns/10ps
`default_nettype none
`include "dmrq_cfg.svh"
module dmrq_top
  import dmrq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`DMRQ_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`DMRQ_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] dma_req_pin,
  input wire logic xfer_done,
  input wire logic [2:0] xfer_chan,
  output logic grant_valid_r,
  output logic [2:0] grant_chan_r,
  output logic [15:0] xfer_addr_r,
  output logic [1:0] xfer_be_r,
  output logic tc_pulse_r
);
  logic [7:0] hw_req;
  logic [7:0] sw_r;
  logic [7:0] mask_r;
  logic [7:0] tc_flag_r;
  logic [7:0] eff_mask;
  logic [7:0] eff_req;
  logic [7:0] tc_ev;
  logic [5:0] ext_r [8];
  logic [15:0] addr_r [8];
  logic [15:0] cnt_r [8];
  logic [15:0] cfg_r;
  dmrq_wr_state_t wr_state_r;
  logic aw_have_r;
  logic w_have_r;
  logic [`DMRQ_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic rvalid_r;
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic [9:0] wix;
  logic [31:0] wd;
  logic wlane0;
  logic wr_req_lo;
  logic wr_req_hi;
  logic wr_msk_lo;
  logic wr_msk_hi;
  logic wr_ext_lo;
  logic wr_ext_hi;
  logic [1:0] clr_grp;
  logic wr_cfg;
  logic wr_load;
  logic wr_known;
  logic rd_take;
  logic [9:0] rix;
  logic [1:0] stat_rd;
  logic [2:0] grant_nxt;
  logic grant_any;
  dmrq_step_in_t stp_in;
  dmrq_step_out_t stp_out;

  dmrq_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(dma_req_pin),
    .q(hw_req)
  );

  // write channel: address and data may arrive in either order
  assign s_axi_awready = !aw_have_r && (wr_state_r == DMRQ_WR_IDLE);
  assign s_axi_wready = !w_have_r && (wr_state_r == DMRQ_WR_IDLE);
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_go = (aw_have_r || aw_take) && (w_have_r || w_take);
  assign wix = aw_have_r ? awaddr_r[`DMRQ_AW-1:2] : s_axi_awaddr[`DMRQ_AW-1:2];
  assign wd = w_have_r ? wdata_r : s_axi_wdata;
  assign wlane0 = wr_go && (w_have_r ? wstrb_r[0] : s_axi_wstrb[0]);
  assign wr_req_lo = wlane0 && (wix == `DMRQ_IX_REQ_LO);
  assign wr_req_hi = wlane0 && (wix == `DMRQ_IX_REQ_HI);
  assign wr_msk_lo = wlane0 && (wix == `DMRQ_IX_MASK_LO);
  assign wr_msk_hi = wlane0 && (wix == `DMRQ_IX_MASK_HI);
  assign wr_ext_lo = wlane0 && (wix == `DMRQ_IX_EXT_LO);
  assign wr_ext_hi = wlane0 && (wix == `DMRQ_IX_EXT_HI);
  assign clr_grp = {wlane0 && (wix == `DMRQ_IX_CLR_HI), wlane0 && (wix == `DMRQ_IX_CLR_LO)};
  assign wr_cfg = wr_go && (wix == `DMRQ_IX_CFG);
  assign wr_load = wr_go && (wix == `DMRQ_IX_LOAD);
  assign wr_known = (wix == `DMRQ_IX_REQ_LO) || (wix == `DMRQ_IX_REQ_HI) ||
                    (wix == `DMRQ_IX_MASK_LO) || (wix == `DMRQ_IX_MASK_HI) ||
                    (wix == `DMRQ_IX_EXT_LO) || (wix == `DMRQ_IX_EXT_HI) ||
                    (wix == `DMRQ_IX_CLR_LO) || (wix == `DMRQ_IX_CLR_HI) ||
                    (wix == `DMRQ_IX_CFG) || (wix == `DMRQ_IX_LOAD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_r <= DMRQ_WR_IDLE;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bresp_r <= `DMRQ_RESP_OKAY;
    end else begin
      unique case (wr_state_r)
        DMRQ_WR_IDLE: begin
          if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            bresp_r <= wr_known ? `DMRQ_RESP_OKAY : `DMRQ_RESP_SLVERR;
            wr_state_r <= DMRQ_WR_RESP;
          end else begin
            if (aw_take) begin
              aw_have_r <= 1'b1;
              awaddr_r <= s_axi_awaddr;
            end
            if (w_take) begin
              w_have_r <= 1'b1;
              wdata_r <= s_axi_wdata;
              wstrb_r <= s_axi_wstrb;
            end
          end
        end
        DMRQ_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_r <= DMRQ_WR_IDLE;
          end
        end
      endcase
    end
  end
  assign s_axi_bvalid = (wr_state_r == DMRQ_WR_RESP);
  assign s_axi_bresp = bresp_r;

  // read channel; a status read also clears that group's terminal-count flags
  assign s_axi_arready = !rvalid_r;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rix = s_axi_araddr[`DMRQ_AW-1:2];
  assign stat_rd = {rd_take && (rix == `DMRQ_IX_STAT_HI), rd_take && (rix == `DMRQ_IX_STAT_LO)};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `DMRQ_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rresp_r <= `DMRQ_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      if (stat_rd[0]) begin
        rdata_r[7:0] <= {eff_req[3:0], tc_flag_r[3:0]};
      end else if (stat_rd[1]) begin
        rdata_r[7:0] <= {eff_req[7:4], tc_flag_r[7:4]};
      end else if (rix == `DMRQ_IX_CFG) begin
        rdata_r[15:0] <= cfg_r;
      end else begin
        rresp_r <= `DMRQ_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // cfg: [7:0] autoinitialise per channel, [15:8] decrement per channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= `DMRQ_CFG_RST;
    end else if (wr_cfg) begin
      cfg_r <= wd[15:0];
    end
  end

  // step engine works on the channel the transfer logic reports
  assign stp_in.mode = dmrq_amode_t'(ext_r[xfer_chan][1:0]);
  assign stp_in.dec = cfg_r[8 + {1'b0, xfer_chan}];
  assign stp_in.addr = addr_r[xfer_chan];
  assign stp_in.cnt = cnt_r[xfer_chan];

  dmrq_step u_step (
    .si(stp_in),
    .so(stp_out)
  );

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_ch
      logic hit;
      logic grp_clr;
      logic wr_req;
      logic wr_msk;
      logic wr_ext;
      assign hit = (wd[1:0] == g[1:0]);
      assign grp_clr = clr_grp[g / 4];
      assign wr_req = ((g < 4) ? wr_req_lo : wr_req_hi) && hit;
      assign wr_msk = ((g < 4) ? wr_msk_lo : wr_msk_hi) && hit;
      assign wr_ext = ((g < 4) ? wr_ext_lo : wr_ext_hi) && hit;
      assign tc_ev[g] = xfer_done && (xfer_chan == g[2:0]) && stp_out.tc;
      if (g < 4) begin : g_cas
        assign eff_mask[g] = mask_r[g] | mask_r[`DMRQ_CASCADE_CH];
      end else begin : g_own
        assign eff_mask[g] = mask_r[g];
      end
      // hardware request gated by mask, software request ORed past it
      assign eff_req[g] = (hw_req[g] & ~eff_mask[g]) | sw_r[g];

      always_ff @(posedge aclk) begin
        if (!aresetn || grp_clr) begin
          sw_r[g] <= 1'b0;
        end else if (tc_ev[g]) begin
          sw_r[g] <= 1'b0;
        end else if (wr_req) begin
          sw_r[g] <= wd[`DMRQ_SETCLR_BIT];
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn || grp_clr) begin
          mask_r[g] <= 1'b1;
        end else if (tc_ev[g] && !cfg_r[g]) begin
          mask_r[g] <= 1'b1;
        end else if (wr_msk) begin
          mask_r[g] <= wd[`DMRQ_SETCLR_BIT];
        end
      end

      // a terminal count in the read cycle survives the clear
      always_ff @(posedge aclk) begin
        if (!aresetn || grp_clr) begin
          tc_flag_r[g] <= 1'b0;
        end else if (tc_ev[g]) begin
          tc_flag_r[g] <= 1'b1;
        end else if (stat_rd[g / 4]) begin
          tc_flag_r[g] <= 1'b0;
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ext_r[g] <= 6'h00;
        end else if (wr_ext) begin
          ext_r[g] <= wd[7:`DMRQ_EXT_LSB];
        end
      end

      // counters keep running on autoinitialise; no base reload is held here
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          addr_r[g] <= 16'h0000;
          cnt_r[g] <= 16'h0000;
        end else if (wr_load && wd[18:`DMRQ_LOAD_CH_LSB] == g[2:0]) begin
          if (wd[`DMRQ_LOAD_CNT_BIT]) begin
            cnt_r[g] <= wd[15:0];
          end else begin
            addr_r[g] <= wd[15:0];
          end
        end else if (xfer_done && xfer_chan == g[2:0]) begin
          addr_r[g] <= stp_out.addr;
          cnt_r[g] <= stp_out.cnt;
        end
      end
    end
  endgenerate

  // fixed priority, lowest channel first; channel four only cascades
  always_comb begin
    grant_nxt = 3'd0;
    grant_any = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (eff_req[i] && i != `DMRQ_CASCADE_CH) begin
        grant_nxt = i[2:0];
        grant_any = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grant_valid_r <= 1'b0;
      grant_chan_r <= 3'd0;
      xfer_addr_r <= 16'h0000;
      xfer_be_r <= 2'b00;
      tc_pulse_r <= 1'b0;
    end else begin
      grant_valid_r <= grant_any;
      grant_chan_r <= grant_nxt;
      tc_pulse_r <= |tc_ev;
      if (xfer_done) begin
        xfer_addr_r <= stp_in.addr;
        xfer_be_r <= stp_out.be;
      end
    end
  end

  sequence s_tc_hit(int c);
    xfer_done && xfer_chan == c[2:0] && stp_out.tc;
  endsequence
  sequence s_mask_on(int c);
    ##1 mask_r[c];
  endsequence

  a_mask_tc_set: assert property (@(posedge aclk) disable iff (!aresetn)
    s_tc_hit(1) ##0 !cfg_r[1] |-> s_mask_on(1))
    else $error("mask not set at terminal count");
  a_sw_tc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    tc_ev[2] |=> !sw_r[2])
    else $error("software request survived terminal count");
  a_clear_masks: assert property (@(posedge aclk) disable iff (!aresetn)
    clr_grp[1] |=> mask_r[7:4] == 4'hf && sw_r[7:4] == 4'h0)
    else $error("clear command left masks or requests");
  a_cascade_block: assert property (@(posedge aclk) disable iff (!aresetn)
    mask_r[4] && !sw_r[0] |-> !eff_req[0])
    else $error("channel zero passed a masked cascade");
  a_sw_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_r[5] && mask_r[5] |-> eff_req[5])
    else $error("software request blocked by mask");
  a_req_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_req_lo && wd[1:0] == 2'b11 && !tc_ev[3] && !clr_grp[0]
    |=> sw_r[3] == $past(wd[2]))
    else $error("request write did not land");
  a_mask_write: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_msk_hi && wd[1:0] == 2'b10 && !tc_ev[6] && !clr_grp[1]
    |=> mask_r[6] == $past(wd[2]))
    else $error("mask write did not land");
  a_status_req: assert property (@(posedge aclk) disable iff (!aresetn)
    stat_rd[0] |=> rvalid_r && rdata_r[7:4] == $past(eff_req[3:0]))
    else $error("status read lost request bits");
  a_byte_step: assert property (@(posedge aclk) disable iff (!aresetn)
    xfer_done && stp_in.mode == DMRQ_AM_16B && !stp_in.dec && !stp_in.addr[0]
    && stp_in.cnt != 16'h0000 |-> stp_out.addr == stp_in.addr + 16'h0002
    && stp_out.cnt == stp_in.cnt - 16'h0002)
    else $error("byte mode step wrong");
endmodule : dmrq_top
`default_nettype wire

// ==== dmrq_periph.sv ====
// Purpose: far side of the request block: request pins and transfer logic
// Assumes: one bus cycle per grant, same clock as the block
// Notes: waits at least three cycles between cycles so a registered grant can drop
`timescale 1ns/10ps
`default_nettype none
module dmrq_periph (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [1:0] gap,
  input wire logic [7:0] hw_lvl,
  input wire logic grant_valid_r,
  input wire logic [2:0] grant_chan_r,
  output logic [7:0] dma_req_pin,
  output logic xfer_done,
  output logic [2:0] xfer_chan
);
  logic [2:0] wait_r;
  assign dma_req_pin = hw_lvl;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xfer_done <= 1'b0;
      xfer_chan <= 3'h0;
      wait_r <= 3'h0;
    end else begin
      xfer_done <= 1'b0;
      // channel is only meaningful with the strobe, so scramble it otherwise
      xfer_chan <= ~xfer_chan;
      if (wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end else if (run && grant_valid_r) begin
        xfer_done <= 1'b1;
        xfer_chan <= grant_chan_r;
        wait_r <= 3'h3 + {1'b0, gap};
      end
    end
  end
endmodule : dmrq_periph
`default_nettype wire

// ==== dmrq_top_tb_top.sv ====
// Purpose: self-checking bench for the request and mask block
// Assumes: dmrq_periph plays the peripherals and the transfer logic
// Notes: model keeps mask, software request and pin images
`timescale 1ns/10ps
`default_nettype none
`include "dmrq_cfg.svh"
module dmrq_top_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [`DMRQ_AW-1:0] awaddr = 12'h000;
  logic [`DMRQ_AW-1:0] araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, run = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [1:0] gap = 2'h0;
  logic [7:0] hw_m = 8'hff, mask_m = 8'hff, sw_m = 8'h00;
  wire logic awready, wready, bvalid, arready, rvalid, xfer_done, gv, tcp;
  wire logic [1:0] bresp, rresp, be_o;
  wire logic [31:0] rdata;
  wire logic [7:0] pins;
  wire logic [2:0] xch, gch;
  wire logic [15:0] addr_o;
  int bad_count = 0;
  int compares = 0;
  integer seed = 32'h2124_dccb;
  logic [18:0] rec_q[$];
  logic d1 = 1'b0;

  always #10 aclk = ~aclk;

  dmrq_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .dma_req_pin(pins), .xfer_done(xfer_done), .xfer_chan(xch),
    .grant_valid_r(gv), .grant_chan_r(gch), .xfer_addr_r(addr_o), .xfer_be_r(be_o),
    .tc_pulse_r(tcp));
  dmrq_periph far_end (.aclk(aclk), .aresetn(aresetn), .run(run), .gap(gap),
    .hw_lvl(hw_m), .grant_valid_r(gv), .grant_chan_r(gch), .dma_req_pin(pins),
    .xfer_done(xfer_done), .xfer_chan(xch));

  // outputs of a cycle settle one edge after the strobe is taken; the tc pulse lasts one cycle
  always @(posedge aclk) begin
    d1 <= xfer_done;
  end
  always @(negedge aclk) if (d1) rec_q.push_back({tcp, be_o, addr_o});

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [9:0] ix, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    awaddr <= {ix, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    // the wait for the response ends when bvalid is seen; only the watchdog bounds it
    forever begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) break;
    end
    chk("bresp", er, r);
  endtask : wr

  task automatic chk_rd(input logic [9:0] ix, input logic [31:0] ed, input logic [1:0] er);
    logic ta, rv;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= {ix, 2'b00};
    arvalid <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = arvalid && arready;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (rv) break;
    end
    chk("rdata", ed, d);
    chk("rresp", er, r);
  endtask : chk_rd

  task automatic chk_state(input logic [3:0] tc_lo);
    logic [7:0] m, e;
    int g;
    repeat (5) @(posedge aclk);
    m = mask_m | {4'h0, {4{mask_m[4]}}};
    e = (hw_m & ~m) | sw_m;
    chk_rd(`DMRQ_IX_STAT_LO, {24'h00_0000, e[3:0], tc_lo}, `DMRQ_RESP_OKAY);
    chk_rd(`DMRQ_IX_STAT_HI, {24'h00_0000, e[7:4], 4'h0}, `DMRQ_RESP_OKAY);
    g = 8;
    for (int i = 7; i >= 0; i--) if (e[i] && i != 4) g = i;
    @(negedge aclk);
    chk("grant_valid", g != 8, gv);
    if (g != 8) chk("grant_chan", g, gch);
    @(posedge aclk);
  endtask : chk_state

  task automatic sel_wr(input logic is_mask, input logic hi, input logic [1:0] ch,
                        input logic set);
    logic [9:0] ix;
    ix = is_mask ? (hi ? `DMRQ_IX_MASK_HI : `DMRQ_IX_MASK_LO)
                 : (hi ? `DMRQ_IX_REQ_HI : `DMRQ_IX_REQ_LO);
    wr(ix, {29'h0000_0000, set, ch}, `DMRQ_RESP_OKAY);
    if (is_mask) mask_m[{hi, ch}] = set;
    else sw_m[{hi, ch}] = set;
  endtask : sel_wr

  task automatic clr_both();
    wr(`DMRQ_IX_CLR_LO, 32'h0000_0000, `DMRQ_RESP_OKAY);
    wr(`DMRQ_IX_CLR_HI, 32'h0000_0000, `DMRQ_RESP_OKAY);
    mask_m = 8'hff;
    sw_m = 8'h00;
  endtask : clr_both

  task automatic wait_rec(input int n);
    int k;
    for (k = 0; k < 400 && rec_q.size() < n; k++) @(posedge aclk);
    run <= 1'b0;
    if (k == 400) chk("transfer_count", n, rec_q.size());
  endtask : wait_rec

  task automatic finish_test();
    $display("counts: %0d compares, %0d mismatches", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  initial begin
    #(20 * 20000);
    bad_count++;
    finish_test();
  end

  initial begin
    int a, c, nb;
    logic [31:0] r;
    logic [18:0] ent;
    logic [1:0] be;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_state(4'h0);
    for (int k = 0; k < 40; k++) begin
      r = $random(seed);
      if (r[5]) hw_m <= r[15:8];
      sel_wr(r[4], r[0], r[2:1], r[3]);
      chk_state(4'h0);
    end
    $display("test random mask and request done");
    chk_rd(`DMRQ_IX_REQ_LO, 32'h0000_0000, `DMRQ_RESP_SLVERR);
    chk_rd(10'h3f0, 32'h0000_0000, `DMRQ_RESP_SLVERR);
    wr(10'h3f0, 32'h0000_0004, `DMRQ_RESP_SLVERR);
    clr_both();
    chk_state(4'h0);
    $display("test refusals and clear done");
    hw_m <= 8'h00;
    gap <= r[17:16];
    // sixteen-bit count-by-bytes on channel 3, meant for 16-bit slaves only
    wr(`DMRQ_IX_EXT_LO, 32'h0000_000f, `DMRQ_RESP_OKAY);
    wr(`DMRQ_IX_LOAD, 32'h0003_0101, `DMRQ_RESP_OKAY);
    // four bytes to move, loaded as total minus one
    wr(`DMRQ_IX_LOAD, 32'h000b_0003, `DMRQ_RESP_OKAY);
    // block mode is taken as already programmed
    rec_q.delete();
    sel_wr(1'b0, 1'b0, 2'd3, 1'b1);
    run <= 1'b1;
    wait_rec(3);
    a = 257;
    c = 3;
    for (int i = 0; i < 3; i++) begin
      be = a[0] ? 2'b10 : (c == 0 ? 2'b01 : 2'b11);
      nb = (be == 2'b11) ? 2 : 1;
      ent = rec_q[i];
      chk("byte_lanes", be, ent[17:16]);
      chk("tc_pulse", c < nb, ent[18]);
      chk("xfer_addr", a, ent[15:0]);
      c = c - nb;
      a = (a & ~1) + 2;
    end
    sw_m[3] = 1'b0;
    chk_state(4'h8);
    $display("test count by bytes done");
    clr_both();
    gap <= r[19:18];
    hw_m <= 8'h04;
    wr(`DMRQ_IX_CFG, 32'h0000_0004, `DMRQ_RESP_OKAY);
    wr(`DMRQ_IX_LOAD, 32'h0009_0000, `DMRQ_RESP_OKAY);
    wr(`DMRQ_IX_LOAD, 32'h000a_0000, `DMRQ_RESP_OKAY);
    // channel four's mask also gates channels zero to three
    sel_wr(1'b1, 1'b1, 2'd0, 1'b0);
    sel_wr(1'b1, 1'b0, 2'd1, 1'b0);
    sel_wr(1'b1, 1'b0, 2'd2, 1'b0);
    sel_wr(1'b0, 1'b0, 2'd1, 1'b1);
    repeat (3) @(posedge aclk);
    rec_q.delete();
    run <= 1'b1;
    wait_rec(2);
    chk("tc_first", 1'b1, rec_q[0][18]);
    chk("tc_second", 1'b1, rec_q[1][18]);
    sw_m[1] = 1'b0;
    mask_m[1] = 1'b1;
    hw_m <= 8'h06;
    chk_state(4'h6);
    chk_state(4'h0);
    chk_rd(`DMRQ_IX_CFG, 32'h0000_0004, `DMRQ_RESP_OKAY);
    $display("test terminal count done");
    finish_test();
  end
endmodule : dmrq_top_tb_top
`default_nettype wire
